// >>> rtl/mlei_top.sv
// top: reset release, strap capture, mode register and request channels
`timescale 1ns/1ps

module mlei_top
    import mlei_pkg::*;
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic mode_strap_a,
    input wire logic mode_strap_b,
    input wire logic mode_strap_c,
    input wire logic pll_init_strap,
    input wire logic clkout_polarity_strap,
    input wire logic [2:0] trig_edge_sel,
    input wire logic irq_a_mask,
    input wire logic irq_b_mask,
    input wire logic [2:0] int_ack,
    input wire logic mode_wr,
    input wire logic [2:0] mode_wr_data,
    input wire logic pll_en_wr,
    input wire logic pll_en_wr_data,
    input wire logic in_stop,
    input wire logic clk_src,
    output logic core_rst_n,
    output logic [2:0] op_mode,
    output logic pll_enable_bit,
    output logic clkout_polarity,
    output logic clock_output,
    output logic ints_active,
    output logic ext_int_req_a,
    output logic ext_int_req_b,
    output logic nmi_req,
    output logic stop_wake
);
    logic [RST_SYNC_STAGES-1:0] rst_sync_q, rst_sync_d;
    mlei_state_t state_q, state_d;
    logic [SETTLE_W-1:0] cnt_q, cnt_d;
    mlei_straps_t straps_q, straps_d;
    logic clk_out_q, clk_out_d;
    logic [NUM_REQ-1:0] pins_n;
    logic [NUM_REQ-1:0] pend;
    logic [NUM_REQ-1:0] lvl_low;
    logic active;
    mlei_reqs_t reqs;

    // internal reset: asserted asynchronously, released on a clock edge
    always_comb begin
        rst_sync_d = {rst_sync_q[RST_SYNC_STAGES-2:0], 1'b1};
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rst_sync_q <= '0;
        end else begin
            rst_sync_q <= rst_sync_d;
        end
    end

    assign core_rst_n = rst_sync_q[RST_SYNC_STAGES-1];

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        straps_d = straps_q;
        case (state_q)
            MLEI_ST_RESET: begin
                // first clocked cycle after release: catch straps
                straps_d.mode = {mode_strap_c, mode_strap_b, mode_strap_a};
                straps_d.pll_enable_bit = pll_init_strap;
                straps_d.clkout_polarity = clkout_polarity_strap;
                cnt_d = '0;
                state_d = MLEI_ST_SETTLE;
            end
            MLEI_ST_SETTLE: begin
                cnt_d = cnt_q + SETTLE_W'(1);
                if (cnt_q == SETTLE_W'(PLL_SETTLE_CYC - 1)) begin
                    state_d = MLEI_ST_RUN;
                end
            end
            MLEI_ST_RUN: begin
                if (mode_wr) begin
                    straps_d.mode = mode_wr_data;
                end
                if (pll_en_wr) begin
                    straps_d.pll_enable_bit = pll_en_wr_data;
                end
            end
            default: begin
                state_d = MLEI_ST_RESET;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge core_rst_n) begin
        if (!core_rst_n) begin
            state_q <= MLEI_ST_RESET;
            cnt_q <= '0;
            straps_q <= '{mode: MODE_RESET_VAL, pll_enable_bit: 1'b0, clkout_polarity: 1'b0};
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            straps_q <= straps_d;
        end
    end

    // clock output follows the source with the strapped polarity
    always_comb begin
        clk_out_d = clk_src ^ straps_q.clkout_polarity;
    end

    always_ff @(posedge sys_clk or negedge core_rst_n) begin
        if (!core_rst_n) begin
            clk_out_q <= 1'b0;
        end else begin
            clk_out_q <= clk_out_d;
        end
    end

    assign active = (state_q == MLEI_ST_RUN);
    assign pins_n = {mode_strap_c, mode_strap_b, mode_strap_a};

    generate
        for (genvar i = 0; i < NUM_REQ; i++) begin : g_chan
            mlei_req_chan u_chan (
                .sys_clk(sys_clk),
                .rst_n(core_rst_n),
                .pin_n(pins_n[i]),
                .active(active),
                .edge_mode(trig_edge_sel[i]),
                .ack(int_ack[i]),
                .pending(pend[i]),
                .level_low(lvl_low[i])
            );

            ack_clear_a: assert property (@(posedge sys_clk) disable iff (!core_rst_n)
                (trig_edge_sel[i] && int_ack[i] && !lvl_low[i])
                |=> (!trig_edge_sel[i] || !pend[i]))
                else $error("acknowledge did not clear the pending request");
        end
    endgenerate

    assign reqs.irq_a = pend[IRQ_A_POS] && !irq_a_mask;
    assign reqs.irq_b = pend[IRQ_B_POS] && !irq_b_mask;
    assign reqs.nmi = pend[NMI_POS];

    assign ext_int_req_a = reqs.irq_a;
    assign ext_int_req_b = reqs.irq_b;
    assign nmi_req = reqs.nmi;
    assign stop_wake = in_stop && (lvl_low[IRQ_A_POS] || pend[IRQ_A_POS]);
    assign op_mode = straps_q.mode;
    assign pll_enable_bit = straps_q.pll_enable_bit;
    assign clkout_polarity = straps_q.clkout_polarity;
    assign clock_output = clk_out_q;
    assign ints_active = active;

    // assertion helper: cycles from strap capture until the requests go live
    logic [SETTLE_W-1:0] settle_seen_q, settle_seen_d;

    always_comb begin
        settle_seen_d = settle_seen_q;
        if (state_q == MLEI_ST_RESET) begin
            settle_seen_d = '0;
        end else if (!active && (settle_seen_q != '1)) begin
            settle_seen_d = settle_seen_q + SETTLE_W'(1);
        end
    end

    always_ff @(posedge sys_clk or negedge core_rst_n) begin
        if (!core_rst_n) begin
            settle_seen_q <= '0;
        end else begin
            settle_seen_q <= settle_seen_d;
        end
    end

    // the sampled core_rst_n keeps the release edge itself, still a reset edge, out
    strap_capture_a: assert property (@(posedge sys_clk) disable iff (!core_rst_n)
        (core_rst_n && state_q == MLEI_ST_RESET) |=> (op_mode == $past(pins_n)))
        else $error("mode not latched at reset release");
    pll_capture_a: assert property (@(posedge sys_clk) disable iff (!core_rst_n)
        (core_rst_n && state_q == MLEI_ST_RESET) |=> (pll_enable_bit == $past(pll_init_strap)))
        else $error("pll enable not taken from strap");
    pol_hold_a: assert property (@(posedge sys_clk) disable iff (!core_rst_n)
        (state_q != MLEI_ST_RESET) |=> $stable(clkout_polarity))
        else $error("clock polarity changed after reset");
    clk_follow_a: assert property (@(posedge sys_clk) disable iff (!core_rst_n)
        $past(core_rst_n) |-> (clock_output == ($past(clk_src) ^ $past(clkout_polarity))))
        else $error("clock output does not follow source and polarity");
    no_int_settle_a: assert property (@(posedge sys_clk) disable iff (!core_rst_n)
        (state_q != MLEI_ST_RUN) |-> !(ext_int_req_a || ext_int_req_b || nmi_req))
        else $error("request raised before handover");
    settle_len_a: assert property (@(posedge sys_clk) disable iff (!core_rst_n)
        $rose(active) |-> (settle_seen_q == SETTLE_W'(PLL_SETTLE_CYC)))
        else $error("handover delay differs from the settling count");
    mode_write_a: assert property (@(posedge sys_clk) disable iff (!core_rst_n)
        (active && mode_wr) |=> (op_mode == $past(mode_wr_data)))
        else $error("software mode write lost");
    settle_write_a: assert property (@(posedge sys_clk) disable iff (!core_rst_n)
        (state_q == MLEI_ST_SETTLE && mode_wr) |=> $stable(op_mode))
        else $error("mode write accepted before handover");
    wake_a: assert property (@(posedge sys_clk) disable iff (!core_rst_n)
        (in_stop && lvl_low[IRQ_A_POS]) |-> stop_wake)
        else $error("request a did not wake from stop");
    a_masked_a: assert property (@(posedge sys_clk) disable iff (!core_rst_n)
        irq_a_mask |-> !ext_int_req_a)
        else $error("masked request a reached the core");
    b_masked_a: assert property (@(posedge sys_clk) disable iff (!core_rst_n)
        irq_b_mask |-> !ext_int_req_b)
        else $error("masked request b reached the core");
    rst_hold_a: assert property (@(posedge sys_clk)
        (!resetn) |=> !core_rst_n)
        else $error("internal reset not held");
    nmi_unmask_a: assert property (@(posedge sys_clk) disable iff (!core_rst_n)
        pend[NMI_POS] |-> nmi_req)
        else $error("non-maskable request was masked");
endmodule

// >>> rtl/mlei_pkg.sv
// package: constants and carrier types for the mode latch and external interrupt block
package mlei_pkg;
    localparam int unsigned SYS_CLK_MHZ = 200;
    // strap-to-interrupt handover delay after reset release, in ns
    localparam int unsigned PLL_SETTLE_NS = 2000;
    localparam int unsigned PLL_SETTLE_CYC = (PLL_SETTLE_NS * SYS_CLK_MHZ) / 1000;
    localparam int unsigned SETTLE_W = 12;
    localparam int unsigned RST_SYNC_STAGES = 2;
    localparam logic [2:0] MODE_RESET_VAL = 3'h0;
    localparam logic [2:0] TRIG_RESET_VAL = 3'h0;
    localparam int unsigned IRQ_A_POS = 0;
    localparam int unsigned IRQ_B_POS = 1;
    localparam int unsigned NMI_POS = 2;
    localparam int unsigned NUM_REQ = 3;

    typedef enum logic [1:0] {
        MLEI_ST_RESET = 2'b00,
        MLEI_ST_SETTLE = 2'b01,
        MLEI_ST_RUN = 2'b10
    } mlei_state_t;

    typedef struct packed {
        logic [2:0] mode;
        logic pll_enable_bit;
        logic clkout_polarity;
    } mlei_straps_t;

    typedef struct packed {
        logic nmi;
        logic irq_b;
        logic irq_a;
    } mlei_reqs_t;
endpackage

// >>> rtl/mlei_req_chan.sv
// one external request channel: synchroniser, edge detect, pending flag
`timescale 1ns/1ps
module mlei_req_chan
    import mlei_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic pin_n,
    input wire logic active,
    input wire logic edge_mode,
    input wire logic ack,
    output logic pending,
    output logic level_low
);
    logic meta_q, meta_d;
    logic sync_q, sync_d;
    logic prev_q, prev_d;
    logic flag_q, flag_d;
    logic fall;

    always_comb begin
        meta_d = pin_n;
        sync_d = meta_q;
        prev_d = sync_q;
        fall = active && prev_q && !sync_q;
        flag_d = flag_q;
        if (ack || !edge_mode || !active) begin
            flag_d = 1'b0;
        end
        if (fall && edge_mode) begin
            flag_d = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= 1'b1;
            sync_q <= 1'b1;
            prev_q <= 1'b1;
            flag_q <= 1'b0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
            prev_q <= prev_d;
            flag_q <= flag_d;
        end
    end

    assign level_low = active && !sync_q;
    assign pending = edge_mode ? flag_q : level_low;

    // a fall in the same cycle as an acknowledge must still leave the flag set
    edge_pend_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (edge_mode && active && $fell(sync_q)) |=> flag_q)
        else $error("falling edge did not set pending");
    level_pend_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (!edge_mode && active && $past(active, 2)) |-> (pending == !$past(pin_n, 2)))
        else $error("level pending does not follow input");
    // the release edge itself still resets the stages, so look only at settled history
    sync_delay_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $past(rst_n, 2) |-> (sync_q == $past(pin_n, 2)))
        else $error("request not synchronised in two stages");
endmodule

// >>> sim/mlei_board.sv
// board model: mode straps around reset, pulled-up request lines afterwards
`timescale 1ns/1ps
module mlei_board
    import mlei_pkg::*;
(
    input wire logic use_req,
    input wire logic [2:0] strap_mode,
    input wire logic [2:0] req_n,
    input wire logic pll_s,
    input wire logic ckp_s,
    output mlei_reqs_t pins,
    output logic pll_pin,
    output logic ckp_pin
);
    // strap_mode passed through until use_req selects the request lines; idle request lines sit high through the pull-ups
    assign pins = use_req ? mlei_reqs_t'(req_n) : mlei_reqs_t'(strap_mode);
    assign pll_pin = pll_s;
    assign ckp_pin = ckp_s;
endmodule

// >>> sim/mlei_top_tb.sv
// self-checking bench for the mode latch and external request block
`timescale 1ns/1ps
module mlei_top_tb
    import mlei_pkg::*;
;
    logic sys_clk = 1'b0, resetn = 1'b0, use_req = 1'b0, pll_s = 1'b0, ckp_s = 1'b0;
    logic irq_a_mask = 1'b0, irq_b_mask = 1'b0, mode_wr = 1'b0, pll_en_wr = 1'b0;
    logic pll_en_wr_data = 1'b0, in_stop = 1'b0, clk_src = 1'b1;
    logic [2:0] strap_mode = 3'h0, req_n = 3'h7, trig_edge_sel = 3'h0;
    logic [2:0] int_ack = 3'h0, mode_wr_data = 3'h0;
    logic core_rst_n, pll_enable_bit, clkout_polarity, clock_output, ints_active;
    logic ext_int_req_a, ext_int_req_b, nmi_req, stop_wake, pll_pin, ckp_pin;
    logic [2:0] op_mode;
    mlei_reqs_t pins;
    wire logic [2:0] reqv = {nmi_req, ext_int_req_b, ext_int_req_a};
    int err_total = 0;
    int compares = 0;

    mlei_board board (.use_req(use_req), .strap_mode(strap_mode), .req_n(req_n),
        .pll_s(pll_s), .ckp_s(ckp_s), .pins(pins), .pll_pin(pll_pin), .ckp_pin(ckp_pin));
    mlei_top dut (.sys_clk(sys_clk), .resetn(resetn), .mode_strap_a(pins.irq_a),
        .mode_strap_b(pins.irq_b), .mode_strap_c(pins.nmi), .pll_init_strap(pll_pin),
        .clkout_polarity_strap(ckp_pin), .trig_edge_sel(trig_edge_sel),
        .irq_a_mask(irq_a_mask), .irq_b_mask(irq_b_mask), .int_ack(int_ack),
        .mode_wr(mode_wr), .mode_wr_data(mode_wr_data), .pll_en_wr(pll_en_wr),
        .pll_en_wr_data(pll_en_wr_data), .in_stop(in_stop), .clk_src(clk_src),
        .core_rst_n(core_rst_n), .op_mode(op_mode), .pll_enable_bit(pll_enable_bit),
        .clkout_polarity(clkout_polarity), .clock_output(clock_output),
        .ints_active(ints_active), .ext_int_req_a(ext_int_req_a),
        .ext_int_req_b(ext_int_req_b), .nmi_req(nmi_req), .stop_wake(stop_wake));

    initial begin
        forever #2.5 sys_clk = ~sys_clk;
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic t_boot(input logic [2:0] m, input logic p, input logic c);
        int n;
        n = 0;
        resetn = 1'b0;
        use_req = 1'b0;
        strap_mode = m;
        pll_s = p;
        ckp_s = c;
        step(8);
        chk({core_rst_n, op_mode, pll_enable_bit, clkout_polarity, ints_active}, 8'h00);
        resetn = 1'b1;
        step(1);
        chk(core_rst_n, 1'b0);
        step(1);
        chk(core_rst_n, 1'b1);
        step(2);
        strap_mode = ~m;
        mode_wr = 1'b1;
        mode_wr_data = ~m;
        step(1);
        mode_wr = 1'b0;
        step(1);
        chk(op_mode[0], m[0]);
        chk(op_mode[1], m[1]);
        chk(op_mode, m);
        chk(pll_enable_bit, p);
        chk({clkout_polarity, clock_output}, {c, ~c});
        clk_src = 1'b0;
        step(1);
        chk(clock_output, c);
        clk_src = 1'b1;
        chk(ints_active, 1'b0);
        while (ints_active !== 1'b1 && n < 600) begin
            step(1);
            n++;
        end
        chk(n > PLL_SETTLE_CYC - 12 && n < PLL_SETTLE_CYC + 8, 1'b1);
        use_req = 1'b1;
        req_n = 3'h7;
        step(3);
        $display("boot test done");
    endtask

    task automatic t_edge();
        trig_edge_sel = 3'h7;
        for (int i = 0; i < 3; i++) begin
            req_n[i] = 1'b0;
            step(4);
            req_n[i] = 1'b1;
            step(4);
            chk(reqv, 3'h1 << i);
            int_ack[i] = 1'b1;
            step(1);
            int_ack = 3'h0;
            step(2);
            chk(reqv, 3'h0);
        end
        $display("edge test done");
    endtask

    task automatic t_level();
        trig_edge_sel = 3'h0;
        irq_a_mask = 1'b1;
        irq_b_mask = 1'b1;
        in_stop = 1'b1;
        req_n = 3'h0;
        step(4);
        chk(reqv, 3'h4);
        chk(stop_wake, 1'b1);
        irq_a_mask = 1'b0;
        irq_b_mask = 1'b0;
        step(1);
        chk(reqv, 3'h7);
        req_n = 3'h7;
        step(4);
        chk({reqv, stop_wake}, 4'h0);
        in_stop = 1'b0;
        $display("level test done");
    endtask

    task automatic t_write();
        mode_wr = 1'b1;
        mode_wr_data = 3'h6;
        pll_en_wr = 1'b1;
        pll_en_wr_data = ~pll_enable_bit;
        step(1);
        mode_wr_data = 3'h1;
        pll_en_wr = 1'b0;
        step(1);
        mode_wr = 1'b0;
        step(1);
        chk(op_mode, 3'h1);
        chk(pll_enable_bit, pll_en_wr_data);
        $display("write test done");
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        #50000;
        err_total++;
        complete_run();
    end

    initial begin
        t_boot(3'h5, 1'b1, 1'b0);
        t_edge();
        t_level();
        t_write();
        t_boot(3'h2, 1'b0, 1'b1);
        t_write();
        complete_run();
    end
endmodule
